// file: crs_card_regs.sv
// Card register set: conditions word, identity, card data, address,
// configuration and status block, read 32 bits at a time.
// Assumes the command engine on CLK drives the request and LOW_VOLTAGE_SWITCH_ACCEPTED/RELATIVE_CARD_ADDRESS updates.
`timescale 1ns/1ns
`include "crs_defs.svh"
module crs_card_regs #(
	parameter int unsigned BUSY_CYCLES = `CRS_BUSY_CYC,
	// Arbitrary neutral identity content
	parameter logic [127:0] IDENTITY = 128'h00000000000000000000000000000001,
	parameter logic [127:0] CARD_DATA = 128'h00000000000000000000000000000001,
	parameter logic [63:0] CONFIG = 64'h0000000000000000,
	parameter logic [511:0] STATUS = 512'h0
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire crs_pkg::crs_req_t REQ,
	input wire logic LOW_VOLTAGE_SWITCH_ACCEPTED_SET,
	input wire logic RCA_WR,
	input wire logic [15:0] RCA_IN,
	output logic RD_VALID,
	output logic [31:0] RD_DATA,
	output crs_pkg::crs_oc_t OPERATING_CONDITIONS,
	output logic READY
);
	// ****************************************
	// State
	// ****************************************
	logic ready;
	logic low_voltage_switch_accepted;
	logic [15:0] relative_card_address;
	crs_pkg::crs_oc_t oc;

	crs_ready_timer #(
		.CYCLES(BUSY_CYCLES)
	) u_timer (
		.clk(CLK),
		.resetn(RESETN),
		.ready(ready)
	);

	// Acceptance is only meaningful once the card is ready
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			low_voltage_switch_accepted <= 1'b0;
		end else if (LOW_VOLTAGE_SWITCH_ACCEPTED_SET && ready) begin
			low_voltage_switch_accepted <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			relative_card_address <= `CRS_RCA_RESET;
		end else if (RCA_WR) begin
			relative_card_address <= RCA_IN;
		end
	end

	// ****************************************
	// Conditions word assembly
	// ****************************************
	always_comb begin
		oc = crs_pkg::crs_oc_t'(`CRS_OC_RESET);
		oc.busy_n = ready;
		oc.capacity = 1'b0;
		oc.low_voltage_switch_accepted = low_voltage_switch_accepted;
	end

	function automatic logic [31:0] pick(input logic [511:0] src, input logic [3:0] w);
		pick = src[w*32 +: 32];
	endfunction

	// No driver stage selector exists: such requests read zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RD_VALID <= 1'b0;
			RD_DATA <= 32'h00000000;
		end else begin
			RD_VALID <= REQ.valid;
			if (REQ.valid) begin
				case (REQ.sel)
					`CRS_SEL_OC: RD_DATA <= oc;
					`CRS_SEL_ID: RD_DATA <= pick({384'h0, IDENTITY}, {2'b00, REQ.word[1:0]});
					`CRS_SEL_CSD: RD_DATA <= pick({384'h0, CARD_DATA}, {2'b00, REQ.word[1:0]});
					`CRS_SEL_RCA: RD_DATA <= {16'h0000, relative_card_address};
					`CRS_SEL_CFG: RD_DATA <= pick({448'h0, CONFIG}, {3'b000, REQ.word[0]});
					`CRS_SEL_STAT: RD_DATA <= pick(STATUS, REQ.word);
					default: RD_DATA <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			OPERATING_CONDITIONS <= crs_pkg::crs_oc_t'(32'h00000000);
			READY <= 1'b0;
		end else begin
			OPERATING_CONDITIONS <= oc;
			READY <= ready;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_fixed_bits;
		@(posedge CLK) disable iff (!RESETN)
		OPERATING_CONDITIONS.window == 9'h1ff || $past(!RESETN);
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("window bits wrong");

	property p_zero_bits;
		@(posedge CLK) disable iff (!RESETN)
		OPERATING_CONDITIONS.rsv_hi == 5'h00 && OPERATING_CONDITIONS.rsv_lo == 15'h0000
			&& !OPERATING_CONDITIONS.capacity;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");

	property p_busy_follows;
		@(posedge CLK) disable iff (!RESETN)
		$rose(ready) |=> OPERATING_CONDITIONS.busy_n;
	endproperty
	a_busy_follows: assert property (p_busy_follows) else $error("busy bit late");

	property p_low_voltage_switch_accepted_needs_ready;
		@(posedge CLK) disable iff (!RESETN)
		!ready |-> !low_voltage_switch_accepted;
	endproperty
	a_low_voltage_switch_accepted_needs_ready: assert property (p_low_voltage_switch_accepted_needs_ready) else $error("low_voltage_switch_accepted early");

	property p_read_oc;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_OC |=> RD_VALID && RD_DATA == $past(oc);
	endproperty
	a_read_oc: assert property (p_read_oc) else $error("conditions read wrong");

	property p_read_rca;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_RCA |=> RD_DATA[15:0] == $past(relative_card_address);
	endproperty
	a_read_rca: assert property (p_read_rca) else $error("address read wrong");

	property p_read_id;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_ID && REQ.word == 4'h0 |=> RD_DATA == IDENTITY[31:0];
	endproperty
	a_read_id: assert property (p_read_id) else $error("identity read wrong");

	property p_no_dsr;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel > `CRS_SEL_STAT |=> RD_DATA == 32'h00000000;
	endproperty
	a_no_dsr: assert property (p_no_dsr) else $error("unmapped read nonzero");

	property p_rd_valid_follows;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid |=> RD_VALID;
	endproperty
	a_rd_valid_follows: assert property (p_rd_valid_follows) else $error("read answer missing");

	property p_rd_valid_single;
		@(posedge CLK) disable iff (!RESETN)
		!REQ.valid |=> !RD_VALID;
	endproperty
	a_rd_valid_single: assert property (p_rd_valid_single) else $error("read answer unasked");

	// Read word must stand until the next request
	property p_rd_data_holds;
		@(posedge CLK) disable iff (!RESETN)
		!REQ.valid |=> $stable(RD_DATA);
	endproperty
	a_rd_data_holds: assert property (p_rd_data_holds) else $error("read word moved");

	property p_low_voltage_switch_accepted_sticky;
		@(posedge CLK) disable iff (!RESETN)
		low_voltage_switch_accepted |=> low_voltage_switch_accepted;
	endproperty
	a_low_voltage_switch_accepted_sticky: assert property (p_low_voltage_switch_accepted_sticky) else $error("low_voltage_switch_accepted dropped");

	property p_low_voltage_switch_accepted_set;
		@(posedge CLK) disable iff (!RESETN)
		LOW_VOLTAGE_SWITCH_ACCEPTED_SET && ready |=> low_voltage_switch_accepted;
	endproperty
	a_low_voltage_switch_accepted_set: assert property (p_low_voltage_switch_accepted_set) else $error("low_voltage_switch_accepted not taken");

	property p_low_voltage_switch_accepted_reflect;
		@(posedge CLK) disable iff (!RESETN)
		OPERATING_CONDITIONS.low_voltage_switch_accepted == $past(low_voltage_switch_accepted);
	endproperty
	a_low_voltage_switch_accepted_reflect: assert property (p_low_voltage_switch_accepted_reflect) else $error("low_voltage_switch_accepted bit wrong");

	property p_busy_reflect;
		@(posedge CLK) disable iff (!RESETN)
		OPERATING_CONDITIONS.busy_n == $past(ready);
	endproperty
	a_busy_reflect: assert property (p_busy_reflect) else $error("busy bit wrong");

	property p_ready_sticky;
		@(posedge CLK) disable iff (!RESETN)
		ready |=> ready;
	endproperty
	a_ready_sticky: assert property (p_ready_sticky) else $error("ready dropped");

	property p_rca_write;
		@(posedge CLK) disable iff (!RESETN)
		RCA_WR |=> relative_card_address == $past(RCA_IN);
	endproperty
	a_rca_write: assert property (p_rca_write) else $error("address write lost");

	property p_rca_hold;
		@(posedge CLK) disable iff (!RESETN)
		!RCA_WR |=> $stable(relative_card_address);
	endproperty
	a_rca_hold: assert property (p_rca_hold) else $error("address changed");

	property p_read_csd;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_CSD && REQ.word[1:0] == 2'h0 |=> RD_DATA == CARD_DATA[31:0];
	endproperty
	a_read_csd: assert property (p_read_csd) else $error("card data read wrong");

	property p_read_cfg;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_CFG && !REQ.word[0] |=> RD_DATA == CONFIG[31:0];
	endproperty
	a_read_cfg: assert property (p_read_cfg) else $error("config read wrong");

	property p_read_stat;
		@(posedge CLK) disable iff (!RESETN)
		REQ.valid && REQ.sel == `CRS_SEL_STAT && REQ.word == 4'h0 |=> RD_DATA == STATUS[31:0];
	endproperty
	a_read_stat: assert property (p_read_stat) else $error("status read wrong");
endmodule // crs_card_regs

// file: crs_defs.svh
// Constants of the card register set: field positions, fixed values, timing.
// Assumes inclusion by the modules of the card register set only.
// Notes on behaviour
// - A 32-bit operating conditions word reports the voltage window and power-up status.
// - Bit 31 reads 0 while busy, 1 once ready; bit 30 reads 0.
// - Bit 24 shows low-voltage switch acceptance and reads 0 initially.
// - Bits 23 to 15 all read 1, one per 0.1 V slice.
// - Bits 29-25, 14-8, 7 and 6-0 always read 0.
// - Identity, card data, relative address, configuration and status block registers exist.
// - No driver stage register exists; nothing steers drive strength.
// - The identity word is fixed per device and defined by its maker.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ****************************************
// Operating conditions word
// ****************************************
`define CRS_OC_BUSY_BIT 31
`define CRS_OC_CAP_BIT 30
`define CRS_OC_LOW_VOLTAGE_SWITCH_ACCEPTED_BIT 24
`define CRS_OC_WIN_HI 23
`define CRS_OC_WIN_LO 15
`define CRS_OC_RESET 32'h00ff8000

// ****************************************
// Register selectors and reset values
// ****************************************
`define CRS_SEL_OC 3'h0
`define CRS_SEL_ID 3'h1
`define CRS_SEL_CSD 3'h2
`define CRS_SEL_RCA 3'h3
`define CRS_SEL_CFG 3'h4
`define CRS_SEL_STAT 3'h5
`define CRS_RCA_RESET 16'h0000
`define CRS_BUSY_NS 1000
`define CRS_BUSY_CYC ((`CRS_BUSY_NS + 19) / 20)

`endif

// file: crs_pkg.sv
// Types of the card register set.
// Assumes crs_defs.svh is on the include path.
package crs_pkg;
	typedef struct packed {
		logic busy_n;
		logic capacity;
		logic [4:0] rsv_hi;
		logic low_voltage_switch_accepted;
		logic [8:0] window;
		logic [14:0] rsv_lo;
	} crs_oc_t;

	typedef struct packed {
		logic valid;
		logic [2:0] sel;
		logic [3:0] word;
	} crs_req_t;
endpackage

// file: crs_ready_timer.sv
// Power-up busy timer: signals ready after a fixed count of cycles.
// Assumes the count is started by reset release.
`timescale 1ns/1ns
`include "crs_defs.svh"
module crs_ready_timer #(
	parameter int unsigned CYCLES = `CRS_BUSY_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	output logic ready
);
	logic [15:0] count;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= 16'h0000;
			ready <= 1'b0;
		end else if (!ready) begin
			if (count == 16'(CYCLES - 1)) begin
				ready <= 1'b1;
			end
			count <= count + 16'h0001;
		end
	end
endmodule // crs_ready_timer

// file: crs_host_model.sv
// Host controller model: issues register reads, polls power-up status.
// Assumes the card register set on the same CLK.
`timescale 1ns/1ns
module crs_host_model (
	input wire logic CLK,
	output crs_pkg::crs_req_t REQ,
	input wire logic RD_VALID,
	input wire logic [31:0] RD_DATA
);
	// ****
	// Read cycle
	// ****
	initial REQ = '0;
	task automatic rd(input logic [2:0] s, input logic [3:0] w, output logic [31:0] d,
		output bit ok);
		@(negedge CLK);
		REQ = '{1'b1, s, w};
		@(negedge CLK);
		// Idle fields toggled so stale values are never trusted
		REQ = '{1'b0, ~s, ~w};
		ok = RD_VALID;
		d = RD_DATA;
	endtask
	task automatic poll(output logic [31:0] d);
		bit ok;
		d = '0;
		for (int i = 0; i < 20 && d[31] !== 1'b1; i++)
			rd(3'h0, 4'h0, d, ok);
	endtask
endmodule // crs_host_model

// file: card_register_set_tb.sv
// Self-checking bench for the card register set.
// Assumes crs_pkg and the host model are compiled first.
`timescale 1ns/1ns
module card_register_set_tb;
	logic CLK = 0, RESETN = 0, LOW_VOLTAGE_SWITCH_ACCEPTED_SET = 0, RCA_WR = 0;
	logic [15:0] RCA_IN = '0;
	crs_pkg::crs_req_t REQ;
	crs_pkg::crs_oc_t OPERATING_CONDITIONS;
	logic RD_VALID, READY;
	logic [31:0] d;
	logic [31:0] RD_DATA;
	logic [2:0] s;
	logic [3:0] w;
	int errors = 0, tests_run = 0;
	bit ok;
	always #10 CLK = ~CLK;
	// Short busy time keeps the run brief
	crs_card_regs #(.BUSY_CYCLES(4)) u_dut (.CLK(CLK), .RESETN(RESETN), .REQ(REQ),
		.LOW_VOLTAGE_SWITCH_ACCEPTED_SET(LOW_VOLTAGE_SWITCH_ACCEPTED_SET), .RCA_WR(RCA_WR), .RCA_IN(RCA_IN), .RD_VALID(RD_VALID),
		.RD_DATA(RD_DATA), .OPERATING_CONDITIONS(OPERATING_CONDITIONS), .READY(READY));
	crs_host_model u_host (.CLK(CLK), .REQ(REQ), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA));
	// ****
	// Checking
	// ****
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask
	// Default identity and card data contents are 1 in word 0 only
	function automatic logic [31:0] exp_word(input logic [2:0] s, input logic [3:0] w);
		return (s inside {3'h1, 3'h2} && w[1:0] == 2'h0) ? 32'h1 : 32'h0;
	endfunction
	task automatic pulse(ref logic p);
		@(negedge CLK);
		p = 1'b1;
		@(negedge CLK);
		p = 1'b0;
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		#500000;
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'h7f18));
		repeat (2) @(negedge CLK);
		RESETN = 1'b1;
		@(negedge CLK);
		check("oc_reset", 32'h00ff8000, OPERATING_CONDITIONS);
		pulse(LOW_VOLTAGE_SWITCH_ACCEPTED_SET);
		check("low_voltage_switch_accepted_busy", 32'h00ff8000, OPERATING_CONDITIONS);
		u_host.poll(d);
		check("oc_ready", 32'h80ff8000, d);
		check("ready", 32'h1, {31'h0, READY});
		pulse(LOW_VOLTAGE_SWITCH_ACCEPTED_SET);
		u_host.rd(3'h0, 4'h0, d, ok);
		check("oc_low_voltage_switch_accepted", 32'h81ff8000, d);
		check("rd_valid", 32'h1, {31'h0, ok});
		RCA_IN = 16'($urandom);
		pulse(RCA_WR);
		u_host.rd(3'h3, 4'h0, d, ok);
		check("rca", {16'h0, RCA_IN}, d);
		for (int i = 0; i < 48; i++) begin
			s = (i < 8) ? 3'(i) : 3'($urandom);
			w = 4'($urandom);
			if (s == 3'h0 || s == 3'h3)
				continue;
			u_host.rd(s, w, d, ok);
			check("word", exp_word(s, w), d);
		end
		RESETN = 1'b0;
		@(negedge CLK);
		check("oc_in_reset", 32'h0, OPERATING_CONDITIONS);
		RESETN = 1'b1;
		@(negedge CLK);
		check("oc_rereset", 32'h00ff8000, OPERATING_CONDITIONS);
		summarize();
	end
endmodule // card_register_set_tb
